// ---- pkg/dpmb_map.svh ----
// Register map, field positions, reset values and timing counts of the mailbox port host.
`ifndef DPMB_MAP_SVH
`define DPMB_MAP_SVH

// APB byte addresses of the host registers.
`define DPMB_CTRL_ADDR    12'h000
`define DPMB_CMD_ADDR     12'h004
`define DPMB_WDATA_ADDR   12'h008
`define DPMB_RDATA_ADDR   12'h00C
`define DPMB_STATUS_ADDR  12'h010

// Control fields.
`define DPMB_CTRL_MASTER  0
`define DPMB_CTRL_INHIBIT 1
`define DPMB_CTRL_RESET   2'h0

// Command fields.
`define DPMB_CMD_ADDR_LSB 0
`define DPMB_CMD_ADDR_MSB 12
`define DPMB_CMD_OP_LSB   16
`define DPMB_CMD_OP_MSB   18
`define DPMB_OP_LAST      3'h5

// Status fields.
`define DPMB_ST_ACTIVE    0
`define DPMB_ST_DONE      1
`define DPMB_ST_IRQ       2
`define DPMB_ST_BUSYHIT   3
`define DPMB_ST_BUSYPIN   4

// Mailbox words of the two ports.
`define DPMB_LEFT_MB      13'h1FFE
`define DPMB_RIGHT_MB     13'h1FFF

// Timing, in ns, and the derived cycle counts at the bus clock.
`define DPMB_CLK_NS       50
`define DPMB_SETUP_NS     20
`define DPMB_SETTLE_NS    30
`define DPMB_STROBE_NS    40
`define DPMB_SYNC_CYC     2
`define DPMB_SETUP_CYC    ((`DPMB_SETUP_NS + `DPMB_CLK_NS - 1) / `DPMB_CLK_NS)
`define DPMB_SETTLE_CYC   ((`DPMB_SETTLE_NS + `DPMB_CLK_NS - 1) / `DPMB_CLK_NS)
`define DPMB_STROBE_CYC   ((`DPMB_STROBE_NS + `DPMB_CLK_NS - 1) / `DPMB_CLK_NS)

`endif

// ---- pkg/dpmb_pkg.sv ----
// Types shared by the mailbox port host modules.
package dpmb_pkg;
    typedef enum logic [2:0] {
        DPMB_OP_ARRAY_RD,
        DPMB_OP_ARRAY_WR,
        DPMB_OP_TOK_RD,
        DPMB_OP_TOK_WR,
        DPMB_OP_MB_POST,
        DPMB_OP_MB_ACK
    } dpmb_op_e;

    typedef enum logic [2:0] {
        DPMB_IDLE,
        DPMB_SETUP,
        DPMB_SETTLE,
        DPMB_STROBE,
        DPMB_RECOVER
    } dpmb_state_e;

    typedef logic [12:0] dpmb_addr_t;
    typedef logic [8:0]  dpmb_data_t;
endpackage

// ---- src/dpmb_port_seq.sv ----
// Pin cycle sequencer that runs one array or token latch access on the RAM port.
`timescale 1ns/1ps
`include "dpmb_map.svh"

module dpmb_port_seq #(
    parameter int SETUP_CYC  = `DPMB_SETUP_CYC,
    parameter int SETTLE_CYC = `DPMB_SETTLE_CYC,
    parameter int STROBE_CYC = `DPMB_STROBE_CYC
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // Request
    input  wire logic              start,
    input  wire logic              wr,
    input  wire logic              tok,
    input  wire dpmb_pkg::dpmb_addr_t addr,
    input  wire dpmb_pkg::dpmb_data_t wdata,
    input  wire logic              master,
    // Synchronised pin levels
    input  wire dpmb_pkg::dpmb_data_t din_s,
    input  wire logic              busy_s,
    // Port pins
    output logic                   ce_n,
    output logic                   oe_n,
    output logic                   rw_n,
    output logic                   token_latch_select_n,
    output dpmb_pkg::dpmb_addr_t   a,
    output dpmb_pkg::dpmb_data_t   dout,
    output logic                   doe,
    // Result
    output logic                   active,
    output logic                   done,
    output logic                   busy_hit,
    output dpmb_pkg::dpmb_data_t   rdata
);
    localparam logic [7:0] SETUP_N  = 8'(SETUP_CYC - 1);
    // The settle count spans the synchroniser so the busy level judged belongs to this access.
    localparam logic [7:0] SETTLE_N = 8'(SETTLE_CYC + `DPMB_SYNC_CYC - 1);
    localparam logic [7:0] STROBE_N = 8'(STROBE_CYC + `DPMB_SYNC_CYC - 1);

    dpmb_pkg::dpmb_state_e state_q, state_d;
    logic [7:0]            cnt_q, cnt_d;
    logic                  wr_q, wr_d, tok_q, tok_d;
    logic                  ce_n_q, ce_n_d, oe_n_q, oe_n_d, rw_n_q, rw_n_d, sel_n_q, sel_n_d;
    dpmb_pkg::dpmb_addr_t  a_q, a_d;
    dpmb_pkg::dpmb_data_t  dout_q, dout_d, rdata_q, rdata_d;
    logic                  doe_q, doe_d, done_q, done_d, hit_q, hit_d;

    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        wr_d    = wr_q;
        tok_d   = tok_q;
        ce_n_d  = ce_n_q;
        oe_n_d  = oe_n_q;
        rw_n_d  = rw_n_q;
        sel_n_d = sel_n_q;
        a_d     = a_q;
        dout_d  = dout_q;
        doe_d   = doe_q;
        rdata_d = rdata_q;
        done_d  = 1'b0;
        hit_d   = 1'b0;
        case (state_q)
            dpmb_pkg::DPMB_IDLE:
            begin
                if (start)
                begin
                    wr_d    = wr;
                    tok_d   = tok;
                    ce_n_d  = tok;
                    sel_n_d = ~tok;
                    a_d     = tok ? {10'h000, addr[2:0]} : addr;
                    dout_d  = wdata;
                    doe_d   = wr;
                    cnt_d   = SETUP_N;
                    state_d = dpmb_pkg::DPMB_SETUP;
                end
            end
            dpmb_pkg::DPMB_SETUP:
            begin
                if (cnt_q == 8'h00)
                begin
                    cnt_d   = SETTLE_N;
                    state_d = dpmb_pkg::DPMB_SETTLE;
                end
                else
                    cnt_d = cnt_q - 8'h01;
            end
            dpmb_pkg::DPMB_SETTLE:
            begin
                // Address and enable stay put until the master's busy verdict is in, so a
                // write pulse never races a glitching inhibit in the slaves.
                if (master && !tok_q && !busy_s)
                begin
                    hit_d = 1'b1;
                    cnt_d = SETTLE_N;
                end
                else if (cnt_q == 8'h00)
                begin
                    rw_n_d  = ~wr_q;
                    oe_n_d  = wr_q;
                    cnt_d   = STROBE_N;
                    state_d = dpmb_pkg::DPMB_STROBE;
                end
                else
                    cnt_d = cnt_q - 8'h01;
            end
            dpmb_pkg::DPMB_STROBE:
            begin
                if (master && !tok_q && !busy_s)
                    hit_d = 1'b1;
                if (cnt_q == 8'h00)
                begin
                    if (!wr_q)
                        rdata_d = din_s;
                    rw_n_d  = 1'b1;
                    oe_n_d  = 1'b1;
                    state_d = dpmb_pkg::DPMB_RECOVER;
                end
                else
                    cnt_d = cnt_q - 8'h01;
            end
            dpmb_pkg::DPMB_RECOVER:
            begin
                ce_n_d  = 1'b1;
                sel_n_d = 1'b1;
                doe_d   = 1'b0;
                done_d  = 1'b1;
                state_d = dpmb_pkg::DPMB_IDLE;
            end
            default:
                state_d = dpmb_pkg::DPMB_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= dpmb_pkg::DPMB_IDLE;
            cnt_q   <= 8'h00;
            wr_q    <= 1'b0;
            tok_q   <= 1'b0;
            ce_n_q  <= 1'b1;
            oe_n_q  <= 1'b1;
            rw_n_q  <= 1'b1;
            sel_n_q <= 1'b1;
            a_q     <= 13'h0000;
            dout_q  <= 9'h000;
            doe_q   <= 1'b0;
            rdata_q <= 9'h000;
            done_q  <= 1'b0;
            hit_q   <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            wr_q    <= wr_d;
            tok_q   <= tok_d;
            ce_n_q  <= ce_n_d;
            oe_n_q  <= oe_n_d;
            rw_n_q  <= rw_n_d;
            sel_n_q <= sel_n_d;
            a_q     <= a_d;
            dout_q  <= dout_d;
            doe_q   <= doe_d;
            rdata_q <= rdata_d;
            done_q  <= done_d;
            hit_q   <= hit_d;
        end
    end

    assign ce_n                 = ce_n_q;
    assign oe_n                 = oe_n_q;
    assign rw_n                 = rw_n_q;
    assign token_latch_select_n = sel_n_q;
    assign a                    = a_q;
    assign dout                 = dout_q;
    assign doe                  = doe_q;
    assign active               = (state_q != dpmb_pkg::DPMB_IDLE);
    assign done                 = done_q;
    assign busy_hit             = hit_q;
    assign rdata                = rdata_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_tok_excludes_array: assert property (!sel_n_q |-> ce_n_q)
        else $error("Token latch select and array enable active together.");
    a_tok_addr_bits: assert property (!sel_n_q |-> a_q[12:3] == 10'h000)
        else $error("Token latch access drives upper address bits.");
    a_write_after_busy: assert property ($fell(rw_n_q) && master && !tok_q |-> $past(busy_s))
        else $error("Write pulse started while busy was low.");
    a_addr_held_write: assert property (!rw_n_q |-> $stable(a_q) && !doe_q == 1'b0)
        else $error("Address or data drive changed during write pulse.");
    a_read_released: assert property (done_q |-> oe_n_q && sel_n_q && ce_n_q)
        else $error("Access ended without releasing enables.");
    a_done_single: assert property (done_q |=> !done_q)
        else $error("Done lasted more than one cycle.");
    c_array_write: cover property ($fell(rw_n_q) && !ce_n_q);
    c_tok_read: cover property ($fell(oe_n_q) && !sel_n_q);
    c_busy_stall: cover property (hit_q && state_q == dpmb_pkg::DPMB_SETTLE);
endmodule

// ---- src/dpmb_host.sv ----
// APB-controlled host that drives one port of the dual-port mailbox RAM through its pins.
`timescale 1ns/1ps
`include "dpmb_map.svh"

// Overview of operation
// - Host holds busy high for normal slave use, low to forbid writes.
// - Exactly one master per width-expanded array; the rest are slaves.
// - Hold address and enable until busy is valid before the write pulse.
// - Depth-cascaded busy signals are ANDed externally into one.
// - Latch access: select low, array enable high, A0-A2 pick the latch.
module dpmb_host #(
    parameter bit LEFT_PORT  = 1'b1,
    parameter int SETUP_CYC  = `DPMB_SETUP_CYC,
    parameter int SETTLE_CYC = `DPMB_SETTLE_CYC,
    parameter int STROBE_CYC = `DPMB_STROBE_CYC
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // RAM port control pins
    output logic             ce_n,
    output logic             oe_n,
    output logic             rw_n,
    output logic             token_latch_select_n,
    output logic [12:0]      a,
    // RAM port data pins
    input  wire logic [8:0]  d_i,
    output logic [8:0]       d_o,
    output logic             d_oe,
    // Own port's mailbox interrupt, active low
    input  wire logic        mailbox_irq_n,
    // Busy pin of this port and role select
    input  wire logic        busy_n_i,
    output logic             busy_n_o,
    output logic             busy_n_oe,
    output logic             role_master
);
    localparam dpmb_pkg::dpmb_addr_t OWN_MB  = LEFT_PORT ? `DPMB_LEFT_MB : `DPMB_RIGHT_MB;
    localparam dpmb_pkg::dpmb_addr_t PEER_MB = LEFT_PORT ? `DPMB_RIGHT_MB : `DPMB_LEFT_MB;

    // Two-flop synchronisers for everything arriving from the RAM.
    logic [8:0] din_m_q, din_s_q;
    logic       busy_m_q, busy_s_q, irq_m_q, irq_s_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            din_m_q  <= 9'h000;
            din_s_q  <= 9'h000;
            busy_m_q <= 1'b1;
            busy_s_q <= 1'b1;
            irq_m_q  <= 1'b1;
            irq_s_q  <= 1'b1;
        end
        else
        begin
            din_m_q  <= d_i;
            din_s_q  <= din_m_q;
            busy_m_q <= busy_n_i;
            busy_s_q <= busy_m_q;
            irq_m_q  <= mailbox_irq_n;
            irq_s_q  <= irq_m_q;
        end
    end

    function automatic logic mapped(input logic [11:0] ad);
        mapped = (ad == `DPMB_CTRL_ADDR) || (ad == `DPMB_CMD_ADDR) || (ad == `DPMB_WDATA_ADDR) ||
                 (ad == `DPMB_RDATA_ADDR) || (ad == `DPMB_STATUS_ADDR);
    endfunction

    logic [1:0]           ctrl_q, ctrl_d;
    dpmb_pkg::dpmb_data_t wdata_q, wdata_d;
    dpmb_pkg::dpmb_addr_t addr_q, addr_d;
    logic                 wr_q, wr_d, tok_q, tok_d, start_q, start_d;
    logic                 done_st_q, done_st_d, hit_st_q, hit_st_d;
    logic                 pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0]          prdata_q, prdata_d;
    logic                 busy_o_q, busy_o_d, busy_oe_q, busy_oe_d;
    logic                 seq_active, seq_done, seq_hit;
    dpmb_pkg::dpmb_data_t seq_rdata;
    dpmb_pkg::dpmb_op_e   op;
    logic                 setup, access, cmd_busy, op_ok;
    logic [31:0]          status;

    assign setup    = psel && !penable;
    assign access   = psel && penable && pready_q;
    assign cmd_busy = seq_active || start_q;
    assign op       = dpmb_pkg::dpmb_op_e'(pwdata[`DPMB_CMD_OP_MSB:`DPMB_CMD_OP_LSB]);
    assign op_ok    = pwdata[`DPMB_CMD_OP_MSB:`DPMB_CMD_OP_LSB] <= `DPMB_OP_LAST;
    assign status   = {27'h0, ~busy_s_q, hit_st_q, ~irq_s_q, done_st_q, seq_active};

    always_comb
    begin
        ctrl_d    = ctrl_q;
        wdata_d   = wdata_q;
        addr_d    = addr_q;
        wr_d      = wr_q;
        tok_d     = tok_q;
        start_d   = 1'b0;
        done_st_d = done_st_q;
        hit_st_d  = hit_st_q;
        pready_d  = setup;
        prdata_d  = prdata_q;
        pslverr_d = 1'b0;
        if (setup)
        begin
            pslverr_d = !mapped(paddr) || (pwrite && paddr == `DPMB_CMD_ADDR && (cmd_busy || !op_ok));
            case (paddr)
                `DPMB_CTRL_ADDR:   prdata_d = {30'h0, ctrl_q};
                `DPMB_WDATA_ADDR:  prdata_d = {23'h0, wdata_q};
                `DPMB_RDATA_ADDR:  prdata_d = {23'h0, seq_rdata};
                `DPMB_STATUS_ADDR: prdata_d = status;
                default:           prdata_d = 32'h00000000;
            endcase
        end
        if (access && pwrite && !pslverr_q)
        begin
            case (paddr)
                `DPMB_CTRL_ADDR:   ctrl_d = pwdata[1:0];
                `DPMB_WDATA_ADDR:  wdata_d = pwdata[8:0];
                `DPMB_STATUS_ADDR:
                begin
                    if (pwdata[`DPMB_ST_DONE])
                        done_st_d = 1'b0;
                    if (pwdata[`DPMB_ST_BUSYHIT])
                        hit_st_d = 1'b0;
                end
                `DPMB_CMD_ADDR:
                begin
                    start_d = 1'b1;
                    addr_d  = pwdata[`DPMB_CMD_ADDR_MSB:`DPMB_CMD_ADDR_LSB];
                    wr_d    = (op == dpmb_pkg::DPMB_OP_ARRAY_WR) || (op == dpmb_pkg::DPMB_OP_TOK_WR) ||
                              (op == dpmb_pkg::DPMB_OP_MB_POST);
                    tok_d   = (op == dpmb_pkg::DPMB_OP_TOK_RD) || (op == dpmb_pkg::DPMB_OP_TOK_WR);
                    if (op == dpmb_pkg::DPMB_OP_MB_POST)
                        addr_d = PEER_MB;
                    if (op == dpmb_pkg::DPMB_OP_MB_ACK)
                        addr_d = OWN_MB;
                end
                default:
                    ctrl_d = ctrl_q;
            endcase
        end
        // Hardware events are applied after the software clear so that a set in the same cycle wins.
        if (seq_done)
            done_st_d = 1'b1;
        if (seq_hit)
            hit_st_d = 1'b1;
        busy_oe_d = !ctrl_d[`DPMB_CTRL_MASTER];
        busy_o_d  = !ctrl_d[`DPMB_CTRL_INHIBIT];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q    <= `DPMB_CTRL_RESET;
            wdata_q   <= 9'h000;
            addr_q    <= 13'h0000;
            wr_q      <= 1'b0;
            tok_q     <= 1'b0;
            start_q   <= 1'b0;
            done_st_q <= 1'b0;
            hit_st_q  <= 1'b0;
            pready_q  <= 1'b0;
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
            busy_o_q  <= 1'b1;
            busy_oe_q <= 1'b1;
        end
        else
        begin
            ctrl_q    <= ctrl_d;
            wdata_q   <= wdata_d;
            addr_q    <= addr_d;
            wr_q      <= wr_d;
            tok_q     <= tok_d;
            start_q   <= start_d;
            done_st_q <= done_st_d;
            hit_st_q  <= hit_st_d;
            pready_q  <= pready_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
            busy_o_q  <= busy_o_d;
            busy_oe_q <= busy_oe_d;
        end
    end

    // The single busy pin may already be the external AND of a depth cascade.
    dpmb_port_seq #(
        .SETUP_CYC  (SETUP_CYC),
        .SETTLE_CYC (SETTLE_CYC),
        .STROBE_CYC (STROBE_CYC)
    ) u_seq (
        .pclk                 (pclk),
        .presetn              (presetn),
        .start                (start_q),
        .wr                   (wr_q),
        .tok                  (tok_q),
        .addr                 (addr_q),
        .wdata                (wdata_q),
        .master               (ctrl_q[`DPMB_CTRL_MASTER]),
        .din_s                (din_s_q),
        .busy_s               (busy_s_q),
        .ce_n                 (ce_n),
        .oe_n                 (oe_n),
        .rw_n                 (rw_n),
        .token_latch_select_n (token_latch_select_n),
        .a                    (a),
        .dout                 (d_o),
        .doe                  (d_oe),
        .active               (seq_active),
        .done                 (seq_done),
        .busy_hit             (seq_hit),
        .rdata                (seq_rdata)
    );

    assign pready      = pready_q;
    assign prdata      = prdata_q;
    assign pslverr     = pslverr_q;
    assign busy_n_o    = busy_o_q;
    assign busy_n_oe   = busy_oe_q;
    assign role_master = ctrl_q[`DPMB_CTRL_MASTER];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_busy_role_drive: assert property (busy_n_oe == !role_master)
        else $error("Busy drive enable does not follow the role.");
    a_busy_inhibit_lvl: assert property (busy_n_oe |-> busy_n_o == !ctrl_q[`DPMB_CTRL_INHIBIT])
        else $error("Busy drive level does not follow inhibit.");
    a_apb_one_wait: assert property (setup |=> pready)
        else $error("APB answer not one cycle after setup.");
    a_start_idle: assert property (start_q |-> !seq_active)
        else $error("Command started while the port was busy.");
    a_done_sticky: assert property (seq_done |=> done_st_q)
        else $error("Done event lost.");
    c_mb_post: cover property (start_q && wr_q && addr_q == PEER_MB);
    c_refused: cover property (setup && pwrite && paddr == `DPMB_CMD_ADDR && cmd_busy);
endmodule

// ---- test/dpmb_ram_model.sv ----
// Behavioural model of the dual-port RAM as seen from its left port.
`timescale 1ns/1ps
module dpmb_ram_model (
    // Left port pins
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        rw_n,
    input  wire logic        sel_n,
    input  wire logic [12:0] a,
    input  wire logic [8:0]  d_o,
    input  wire logic        d_oe,
    output logic [8:0]       d_i,
    output logic             left_irq_n,
    output logic             right_irq_n,
    // Busy and role
    input  wire logic        role_master,
    input  wire logic        busy_n_o,
    input  wire logic        busy_n_oe,
    output logic             busy_n,
    // Right port activity
    input  wire logic        peer_post,
    input  wire logic        peer_hit,
    input  wire logic [7:0]  peer_own
);
    logic [8:0] mem [0:8191];
    logic [7:0] own, pend;
    logic [8:0] last, tok_q;
    // The slave pin has a pull-up when nobody drives it.
    assign busy_n = role_master ? !(peer_hit && !ce_n) : (busy_n_oe ? busy_n_o : 1'h1);
    initial begin own = 8'h00; pend = 8'h00; left_irq_n = 1'h1; right_irq_n = 1'h1; last = 9'h000; end
    always @(posedge rw_n)
        if (d_oe && busy_n)
        begin
            if (!ce_n) begin mem[a] = d_o; if (a == 13'h1FFF) right_irq_n = 1'h0; end
            else if (!sel_n && !d_o[0]) begin if (peer_own[a[2:0]]) pend[a[2:0]] = 1'h1; else own[a[2:0]] = 1'h1; end
            else if (!sel_n) begin own[a[2:0]] = 1'h0; pend[a[2:0]] = 1'h0; end
        end
    always @(peer_own) begin own = own | (pend & ~peer_own); pend = pend & peer_own; end
    always @(negedge (sel_n | oe_n)) tok_q = {9{~own[a[2:0]]}};
    always @(posedge peer_post) left_irq_n = 1'h0;
    always @(negedge oe_n) if (!ce_n && a == 13'h1FFE) left_irq_n = 1'h1;
    // A released bus shows the inverse of the last value driven, never a stale copy.
    always @*
        if (!oe_n && !ce_n) begin d_i = mem[a]; last = mem[a]; end
        else if (!oe_n && !sel_n) begin d_i = tok_q; last = tok_q; end
        else d_i = ~last;
endmodule

// ---- test/dpmb_host_tb.sv ----
// Self-checking bench for the APB mailbox port host.
`timescale 1ns/1ps
`include "dpmb_map.svh"
module dpmb_host_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        ce_n, oe_n, rw_n, sel_n, d_oe, busy_n_o, busy_n_oe, role_master, busy_n;
    logic        left_irq_n, right_irq_n, peer_post, peer_hit;
    logic [12:0] a, ad;
    logic [8:0]  d_i, d_o, dt;
    logic [7:0]  peer_own;
    logic [12:0] adrs [6];
    logic [8:0]  dats [6];
    int          num_errors, n_tests, seed, i;
    dpmb_host u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .ce_n(ce_n),
        .oe_n(oe_n), .rw_n(rw_n), .token_latch_select_n(sel_n), .a(a), .d_i(d_i), .d_o(d_o), .d_oe(d_oe),
        .mailbox_irq_n(left_irq_n), .busy_n_i(busy_n), .busy_n_o(busy_n_o), .busy_n_oe(busy_n_oe),
        .role_master(role_master));
    dpmb_ram_model u_ram (.ce_n(ce_n), .oe_n(oe_n), .rw_n(rw_n), .sel_n(sel_n), .a(a), .d_o(d_o),
        .d_oe(d_oe), .d_i(d_i), .left_irq_n(left_irq_n), .right_irq_n(right_irq_n),
        .role_master(role_master), .busy_n_o(busy_n_o), .busy_n_oe(busy_n_oe), .busy_n(busy_n),
        .peer_post(peer_post), .peer_hit(peer_hit), .peer_own(peer_own));
    initial begin pclk = 1'h0; forever #25 pclk = ~pclk; end
    function automatic logic [31:0] cmdw(input logic [12:0] ad, input logic [2:0] op);
        return {13'h0000, op, 3'h0, ad};
    endfunction
    function automatic logic [31:0] semv(input logic owned);
        return owned ? 32'h00000000 : 32'h000001FF;
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        n_tests++;
        if (seen !== ex)
        begin
            num_errors++;
            $display("[ERR] %s expected %0h seen %0h", nm, ex, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= ad; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata; er = pslverr;
        psel <= 1'h0; penable <= 1'h0;
    endtask
    // Runs one pin cycle and leaves its read data in rd, with status bits 3:0 in rd[31:28].
    task automatic cmd(input logic [12:0] ad, input logic [2:0] op, input logic [8:0] wd);
        logic [31:0] st;
        apb(1'h1, `DPMB_WDATA_ADDR, {23'h000000, wd});
        apb(1'h1, `DPMB_CMD_ADDR, cmdw(ad, op)); check("cmd err", er, 32'h0);
        st = 32'h00000000;
        for (int k = 0; k < 60 && !st[1]; k++) begin apb(1'h0, `DPMB_STATUS_ADDR, 32'h0); st = rd; end
        check("cmd done", st[1], 32'h1);
        apb(1'h1, `DPMB_STATUS_ADDR, 32'h0000000A);
        apb(1'h0, `DPMB_RDATA_ADDR, 32'h0);
        rd = {st[3:0], rd[27:0]};
    endtask
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin repeat (30000) @(posedge pclk); num_errors++; end_of_test; end
    initial begin
        seed = 25; presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 12'h000;
        pwdata = 32'h0; peer_post = 1'h0; peer_hit = 1'h0; peer_own = 8'h00;
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        check("idle pins", {ce_n, sel_n, d_oe, busy_n_oe}, 32'h0000000D);
        apb(1'h0, 12'hFFC, 32'h0); check("unmapped err", er, 32'h1);
        apb(1'h1, `DPMB_CMD_ADDR, cmdw(13'h0000, 3'h6)); check("bad op err", er, 32'h1);
        for (i = 0; i < 6; i++) begin adrs[i] = 13'($random(seed)); dats[i] = 9'($random(seed)); cmd(adrs[i], 3'h1, dats[i]); end
        for (i = 0; i < 6; i++) begin cmd(adrs[i], 3'h0, 9'h000); check("array rd", rd[8:0], dats[i]); end
        cmd(13'h0000, 3'h4, 9'h15A); check("right irq", right_irq_n, 32'h0);
        cmd(13'h1FFF, 3'h0, 9'h000); check("post data", rd[8:0], 32'h15A);
        cmd(13'h1FFE, 3'h1, 9'h0C3);
        @(posedge pclk) peer_post <= 1'h1;
        repeat (2) @(posedge pclk);
        apb(1'h0, `DPMB_STATUS_ADDR, 32'h0); check("irq set", rd[2], 32'h1);
        cmd(13'h0000, 3'h5, 9'h000); check("ack data", rd[8:0], 32'h0C3);
        apb(1'h0, `DPMB_STATUS_ADDR, 32'h0); check("irq clr", rd[2], 32'h0);
        peer_own <= 8'h08;
        for (i = 0; i < 8; i++) begin ad = 13'($random(seed)); cmd({ad[12:3], i[2:0]}, 3'h3, 9'h1FE);
            cmd({ad[12:3], i[2:0]}, 3'h2, 9'h000); check("take", rd[8:0], semv(i != 3)); end
        peer_own <= 8'h00;
        cmd(13'h0003, 3'h2, 9'h000); check("pending", rd[8:0], semv(1'h1));
        for (i = 0; i < 8; i++) begin cmd(13'(i), 3'h3, 9'h001); cmd(13'(i), 3'h2, 9'h000); check("free", rd[8:0], semv(1'h0)); end
        apb(1'h1, `DPMB_CTRL_ADDR, 32'h1); @(posedge pclk); check("master pins", {role_master, busy_n_oe}, 32'h2);
        peer_hit <= 1'h1;
        fork begin repeat (40) @(posedge pclk); peer_hit <= 1'h0; end join_none
        cmd(13'h0100, 3'h1, 9'h0A5); check("busy hit", rd[31], 32'h1);
        cmd(13'h0100, 3'h0, 9'h000); check("after busy", rd[8:0], 32'h0A5);
        apb(1'h1, `DPMB_CMD_ADDR, cmdw(13'h0100, 3'h0)); check("first cmd", er, 32'h0);
        apb(1'h1, `DPMB_CMD_ADDR, cmdw(13'h0100, 3'h0)); check("refused cmd", er, 32'h1);
        repeat (20) @(posedge pclk);
        apb(1'h1, `DPMB_STATUS_ADDR, 32'h0000000A);
        apb(1'h1, `DPMB_CTRL_ADDR, 32'h2); @(posedge pclk); check("inhibit pins", {role_master, busy_n_oe, busy_n_o}, 32'h2);
        cmd(13'h0100, 3'h1, 9'h05A); cmd(13'h0100, 3'h0, 9'h000); check("inhibited", rd[8:0], 32'h0A5);
        apb(1'h1, `DPMB_CTRL_ADDR, 32'h0);
        cmd(13'h0100, 3'h1, 9'h05A); cmd(13'h0100, 3'h0, 9'h000); check("slave wr", rd[8:0], 32'h05A);
        end_of_test;
    end
endmodule
